//--- bcl_map.svh
// Purpose: Offsets, field positions and reset values of the boot latches
// Assumes: Included by bare name from each design file
// Notes: Latch bytes sit at word index 0..3, byte address is four times the index
`ifndef BCL_MAP_SVH
`define BCL_MAP_SVH

`define BCL_IDX_PORT_DRIVE_LOW 3'h0
`define BCL_IDX_PORT_DRIVE_HIGH 3'h1
`define BCL_IDX_RESET_DEBUG_CTRL 3'h2
`define BCL_IDX_BOOT_CLOCK_ECC 3'h3
`define BCL_IDX_STATUS 3'h4
`define BCL_IDX_APPLIED 3'h5
`define BCL_LATCH_BYTES 4

`define BCL_POS_EXT_RESET 7
`define BCL_POS_DEBUG_ACCESS 6
`define BCL_POS_PRT15_MODE 0
`define BCL_POS_PHASE_DELAY 4
`define BCL_POS_ECC_REGION 3
`define BCL_POS_DEBUG_PORT 1
`define BCL_POS_BOOT_CLOCK 0
`define BCL_POS_STS_VALID 0
`define BCL_POS_STS_WCOUNT 16

`define BCL_RST_PORT_DRIVE_LOW 8'h00
`define BCL_RST_PORT_DRIVE_HIGH 8'h00
`define BCL_RST_RESET_DEBUG_CTRL 8'h40
`define BCL_RST_BOOT_CLOCK_ECC 8'h0A

`define BCL_WCOUNT_MAX 16'hFFFF

`endif

//--- bcl_pkg.sv
// Purpose: Types shared by the boot latch design files
// Assumes: Enum order matches the latch field encodings
// Notes: Drive and debug port enums are decoded straight from latch bits
package bcl_pkg;

    typedef enum logic [1:0] {
        BCL_DRV_HIZ_ANALOG,
        BCL_DRV_HIZ_DIGITAL,
        BCL_DRV_PULL_UP,
        BCL_DRV_PULL_DOWN
    } bcl_drive_e;

    typedef enum logic [1:0] {
        BCL_DBG_JTAG5,
        BCL_DBG_JTAG4,
        BCL_DBG_SWD,
        BCL_DBG_OFF
    } bcl_dbgport_e;

    typedef enum logic [1:0] {
        BCL_LD_FETCH,
        BCL_LD_DONE
    } bcl_load_e;

    typedef enum logic [1:0] {
        BCL_BUS_IDLE,
        BCL_BUS_RESP,
        BCL_BUS_DONE
    } bcl_bus_e;

endpackage : bcl_pkg

//--- bcl_latch_mem.sv
// Purpose: Four byte configuration latch array with registered read
// Assumes: por_rst only at power-up, sys_rst does not reach this array
// Notes: Contents survive system reset, as nonvolatile latches must
`timescale 1ns/1ps
`include "bcl_map.svh"

module bcl_latch_mem (
    input wire logic mclk,
    input wire logic por_rst,
    input wire logic wr_en,
    input wire logic [1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] cell_reg [`BCL_LATCH_BYTES];

    // Factory image loaded only at power-up
    always_ff @(posedge mclk or posedge por_rst) begin
        if (por_rst) begin
            cell_reg[0] <= `BCL_RST_PORT_DRIVE_LOW;
            cell_reg[1] <= `BCL_RST_PORT_DRIVE_HIGH;
            cell_reg[2] <= `BCL_RST_RESET_DEBUG_CTRL;
            cell_reg[3] <= `BCL_RST_BOOT_CLOCK_ECC;
        end else if (wr_en) begin
            cell_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk or posedge por_rst) begin
        if (por_rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= cell_reg[rd_addr];
        end
    end
endmodule : bcl_latch_mem

//--- bcl_wear_cnt.sv
// Purpose: Saturating count of latch write cycles
// Assumes: bump is a one-cycle pulse per accepted latch write
// Notes: Lets software see how much of the limited endurance it has used
`timescale 1ns/1ps
`include "bcl_map.svh"

module bcl_wear_cnt (
    input wire logic mclk,
    input wire logic por_rst,
    input wire logic bump,
    output logic [15:0] count
);
    // Saturates rather than wraps so a worn array never looks fresh
    always_ff @(posedge mclk or posedge por_rst) begin
        if (por_rst) begin
            count <= 16'h0000;
        end else if (bump && count != `BCL_WCOUNT_MAX) begin
            count <= count + 16'h0001;
        end
    end
endmodule : bcl_wear_cnt

//--- bcl_boot_config_latches.sv
// Purpose: Boot configuration latches, loaded into applied settings at reset
// Assumes: Avalon-MM slave with waitrequest, byte address, 32-bit data
// Notes: Latch writes change the array only; settings follow at next reset
//
// Notes on behaviour
// RULE1: Four latch bytes are read and applied after every reset release.
// RULE2: Each I/O port has a two-bit reset drive mode for all pins.
// RULE3: Drive mode codes: analog hi-Z, digital hi-Z, pull-up, pull-down.
// RULE4: External reset select: 0 keeps GPIO, 1 makes an external reset.
// RULE5: Debug access enable: 0 blocks debug, 1 allows it, default 1.
// RULE6: Boot clock speed: 0 gives 12 MHz, 1 gives 48 MHz, default 0.
// RULE7: Debug port select: 5-wire JTAG, 4-wire JTAG default, SWD, off.
// RULE8: ECC region enable: 1 keeps ECC use, 0 frees it, default 1.
// RULE9: Four-bit digital clock phase delay field taken from the array.
// RULE10: Software keeps latch rewrites few, endurance is limited.
// RULE11: Applied settings stay fixed until the next reset.
`timescale 1ns/1ps
`include "bcl_map.svh"

module bcl_boot_config_latches import bcl_pkg::*; (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic config_valid,
    output bcl_drive_e prt0_reset_drive_mode,
    output bcl_drive_e prt1_reset_drive_mode,
    output bcl_drive_e prt2_reset_drive_mode,
    output bcl_drive_e prt3_reset_drive_mode,
    output bcl_drive_e prt4_reset_drive_mode,
    output bcl_drive_e prt5_reset_drive_mode,
    output bcl_drive_e prt6_reset_drive_mode,
    output bcl_drive_e prt12_reset_drive_mode,
    output bcl_drive_e prt15_reset_drive_mode,
    output logic ext_reset_pin_select,
    output logic debug_access_enable,
    output logic boot_clock_speed,
    output bcl_dbgport_e debug_port_select,
    output logic ecc_region_enable,
    output logic [3:0] digital_clock_phase_delay
);

    function automatic bcl_drive_e drive_slot(input logic [7:0] b, input logic [1:0] slot);
        logic [7:0] s;
        s = b >> {slot, 1'b0};
        return bcl_drive_e'(s[1:0]);
    endfunction : drive_slot

    function automatic logic [2:0] word_index(input logic [4:0] addr);
        return addr[4:2];
    endfunction : word_index

    logic [7:0] app_reg [`BCL_LATCH_BYTES];
    bcl_load_e ld_st_reg;
    logic [1:0] ld_idx_reg;
    logic ld_pend_reg;
    logic [1:0] ld_pidx_reg;
    logic config_valid_reg;
    bcl_bus_e bus_st_reg;
    logic [2:0] bus_idx_reg;
    logic [31:0] readdata_reg;
    logic waitrequest_reg;
    logic mem_we;
    logic [1:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic [15:0] wear_count;
    logic bus_take;
    logic [2:0] req_idx;

    assign req_idx = word_index(avs_address);
    // Bus waits until the boot load owns the array no more
    assign bus_take = (bus_st_reg == BCL_BUS_IDLE) && config_valid_reg && (avs_read || avs_write);
    // RULE10: write gating, only byte lane 0 of a latch word reaches the array
    assign mem_we = bus_take && avs_write && (req_idx < 3'(`BCL_LATCH_BYTES))
        && avs_byteenable[0];
    assign mem_raddr = (ld_st_reg == BCL_LD_FETCH) ? ld_idx_reg : req_idx[1:0];

    bcl_latch_mem u_mem (
        .mclk(mclk),
        .por_rst(por_rst),
        .wr_en(mem_we),
        .wr_addr(req_idx[1:0]),
        .wr_data(avs_writedata[7:0]),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    bcl_wear_cnt u_wear (
        .mclk(mclk),
        .por_rst(por_rst),
        .bump(mem_we),
        .count(wear_count)
    );

    // RULE1: fetch sequence after reset
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ld_st_reg <= BCL_LD_FETCH;
            ld_idx_reg <= 2'h0;
            ld_pend_reg <= 1'b0;
            ld_pidx_reg <= 2'h0;
        end else begin
            ld_pidx_reg <= ld_idx_reg;
            case (ld_st_reg)
                BCL_LD_FETCH: begin
                    ld_pend_reg <= 1'b1;
                    ld_idx_reg <= ld_idx_reg + 2'h1;
                    if (ld_idx_reg == 2'h3) begin
                        ld_st_reg <= BCL_LD_DONE;
                    end
                end
                BCL_LD_DONE: begin
                    ld_pend_reg <= 1'b0;
                end
                default: begin
                    ld_st_reg <= BCL_LD_DONE;
                end
            endcase
        end
    end

    // RULE11: applied bytes change only during the boot fetch
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            app_reg[0] <= `BCL_RST_PORT_DRIVE_LOW;
            app_reg[1] <= `BCL_RST_PORT_DRIVE_HIGH;
            app_reg[2] <= `BCL_RST_RESET_DEBUG_CTRL;
            app_reg[3] <= `BCL_RST_BOOT_CLOCK_ECC;
        end else if (ld_pend_reg && !config_valid_reg) begin
            app_reg[ld_pidx_reg] <= mem_rdata;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            config_valid_reg <= 1'b0;
        end else if (ld_st_reg == BCL_LD_DONE && ld_pend_reg) begin
            config_valid_reg <= 1'b1;
        end
    end

    // Fixed two-edge answer keeps the master timing simple to predict
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_st_reg <= BCL_BUS_IDLE;
            bus_idx_reg <= 3'h0;
            readdata_reg <= 32'h0000_0000;
            waitrequest_reg <= 1'b1;
        end else begin
            case (bus_st_reg)
                BCL_BUS_IDLE: begin
                    waitrequest_reg <= 1'b1;
                    if (bus_take) begin
                        bus_idx_reg <= req_idx;
                        bus_st_reg <= BCL_BUS_RESP;
                    end
                end
                BCL_BUS_RESP: begin
                    waitrequest_reg <= 1'b0;
                    bus_st_reg <= BCL_BUS_DONE;
                    if (avs_read) begin
                        if (bus_idx_reg < 3'(`BCL_LATCH_BYTES)) begin
                            readdata_reg <= {24'h00_0000, mem_rdata};
                        end else if (bus_idx_reg == `BCL_IDX_STATUS) begin
                            readdata_reg <= {wear_count, 15'h0000, config_valid_reg};
                        end else if (bus_idx_reg == `BCL_IDX_APPLIED) begin
                            readdata_reg <= {app_reg[3], app_reg[2], app_reg[1], app_reg[0]};
                        end else begin
                            readdata_reg <= 32'h0000_0000;
                        end
                    end
                end
                BCL_BUS_DONE: begin
                    waitrequest_reg <= 1'b1;
                    bus_st_reg <= BCL_BUS_IDLE;
                end
                default: begin
                    waitrequest_reg <= 1'b1;
                    bus_st_reg <= BCL_BUS_IDLE;
                end
            endcase
        end
    end

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign config_valid = config_valid_reg;

    // RULE2: one mode per port from the applied bytes
    // RULE3: codes map directly onto the drive enum
    assign prt0_reset_drive_mode = drive_slot(app_reg[0], 2'h0);
    assign prt1_reset_drive_mode = drive_slot(app_reg[0], 2'h1);
    assign prt2_reset_drive_mode = drive_slot(app_reg[0], 2'h2);
    assign prt3_reset_drive_mode = drive_slot(app_reg[0], 2'h3);
    assign prt4_reset_drive_mode = drive_slot(app_reg[1], 2'h0);
    assign prt5_reset_drive_mode = drive_slot(app_reg[1], 2'h1);
    assign prt6_reset_drive_mode = drive_slot(app_reg[1], 2'h2);
    assign prt12_reset_drive_mode = drive_slot(app_reg[1], 2'h3);
    assign prt15_reset_drive_mode = drive_slot(app_reg[2], 2'(`BCL_POS_PRT15_MODE));
    // RULE4: external reset pin select
    assign ext_reset_pin_select = app_reg[2][`BCL_POS_EXT_RESET];
    // RULE5: debug access gate
    assign debug_access_enable = app_reg[2][`BCL_POS_DEBUG_ACCESS];
    // RULE6: boot oscillator speed, 1 means 48 MHz
    assign boot_clock_speed = app_reg[3][`BCL_POS_BOOT_CLOCK];
    // RULE7: debug port selection
    assign debug_port_select = bcl_dbgport_e'(app_reg[3][`BCL_POS_DEBUG_PORT +: 2]);
    // RULE8: ECC region use
    assign ecc_region_enable = app_reg[3][`BCL_POS_ECC_REGION];
    // RULE9: phase delay field
    assign digital_clock_phase_delay = app_reg[3][`BCL_POS_PHASE_DELAY +: 4];

endmodule : bcl_boot_config_latches

//--- bcl_boot_config_latches_assertions.sv
// Purpose: Bus timing and applied setting checks for the boot latches
// Assumes: Bound to the top module, ports watched by name
// Notes: Field checks go through the applied readback word
`timescale 1ns/1ps
module bcl_boot_config_latches_assertions import bcl_pkg::*; (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic config_valid,
    input wire bcl_drive_e prt0_reset_drive_mode,
    input wire logic ext_reset_pin_select,
    input wire logic debug_access_enable,
    input wire logic boot_clock_speed,
    input wire bcl_dbgport_e debug_port_select,
    input wire logic ecc_region_enable,
    input wire logic [3:0] digital_clock_phase_delay
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic rd_ans;
    assign rd_ans = avs_read && !avs_waitrequest;
    sequence s_answer;
        avs_waitrequest [*2] ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_valid_after_load: assert property ($fell(sys_rst) |->
        !config_valid [*5] ##1 config_valid)
        else $error("config_valid timing wrong after reset");
    a_hold_settings: assert property (config_valid && $past(config_valid) |->
        $stable(debug_access_enable) && $stable(debug_port_select) && $stable(boot_clock_speed))
        else $error("applied setting changed without reset");
    a_factory_reset: assert property (disable iff (por_rst) sys_rst |->
        debug_access_enable && debug_port_select == BCL_DBG_JTAG4 && ecc_region_enable
        && !boot_clock_speed && !ext_reset_pin_select
        && prt0_reset_drive_mode == BCL_DRV_HIZ_ANALOG)
        else $error("outputs not at factory values in reset");
    a_early_wait: assert property (!config_valid |-> avs_waitrequest)
        else $error("answer before settings loaded");
    a_answer_time: assert property (($rose(avs_read) || $rose(avs_write)) && config_valid
        |-> s_answer) else $error("bus answer not two edges after take");
    a_upper_zero: assert property (rd_ans && avs_address[4:2] < 3'h4
        |-> avs_readdata[31:8] == 24'h000000) else $error("latch word upper bits set");
    a_unmapped_zero: assert property (rd_ans && avs_address[4:3] == 2'b11
        |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
    a_applied_fields: assert property (rd_ans && avs_address[4:2] == 3'h5 |->
        avs_readdata[31:22] == {digital_clock_phase_delay, ecc_region_enable, debug_port_select,
        boot_clock_speed, ext_reset_pin_select, debug_access_enable}
        && avs_readdata[1:0] == prt0_reset_drive_mode) else $error("applied readback mismatch");
endmodule : bcl_boot_config_latches_assertions

bind bcl_boot_config_latches bcl_boot_config_latches_assertions
    u_bcl_boot_config_latches_assertions (
    .mclk, .sys_rst, .por_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .config_valid, .prt0_reset_drive_mode, .ext_reset_pin_select,
    .debug_access_enable, .boot_clock_speed, .debug_port_select, .ecc_region_enable,
    .digital_clock_phase_delay);

//--- bcl_boot_config_latches_tb.sv
// Purpose: Self-checking bench for the boot configuration latches
// Assumes: por_rst and sys_rst raised together at start
// Notes: Each latch image only shows after a sys_rst pulse
`timescale 1ns/1ps
module bcl_boot_config_latches_tb import bcl_pkg::*; ;
    logic mclk = 0, sys_rst = 1, por_rst = 1, avs_read = 0, avs_write = 0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd, prev;
    logic [3:0] avs_byteenable = 4'hF, phase;
    logic avs_waitrequest, config_valid, ext_sel, dbg_en, clk_sel, ecc_en;
    bcl_drive_e drv [9];
    bcl_dbgport_e dbg_port;
    int n_mismatch = 0, samples_checked = 0;
    logic [31:0] rows [4] = '{32'h50821BE4, 32'hAB43E41B, 32'hF501AA55, 32'h0E400000};
    wire [31:0] applied = {phase, ecc_en, dbg_port, clk_sel, ext_sel, dbg_en, 4'h0, drv[8],
        drv[7], drv[6], drv[5], drv[4], drv[3], drv[2], drv[1], drv[0]};
    always #12.5 mclk = ~mclk;
    bcl_boot_config_latches u_bcl_boot_config_latches (.mclk(mclk), .sys_rst(sys_rst),
        .por_rst(por_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .config_valid(config_valid), .prt0_reset_drive_mode(drv[0]),
        .prt1_reset_drive_mode(drv[1]), .prt2_reset_drive_mode(drv[2]),
        .prt3_reset_drive_mode(drv[3]), .prt4_reset_drive_mode(drv[4]),
        .prt5_reset_drive_mode(drv[5]), .prt6_reset_drive_mode(drv[6]),
        .prt12_reset_drive_mode(drv[7]), .prt15_reset_drive_mode(drv[8]),
        .ext_reset_pin_select(ext_sel), .debug_access_enable(dbg_en),
        .boot_clock_speed(clk_sel), .debug_port_select(dbg_port), .ecc_region_enable(ecc_en),
        .digital_clock_phase_delay(phase));
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Request held until waitrequest is sampled low, released on that edge
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task restart();
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        check("factory in reset", 32'h0A400000, applied);
        sys_rst <= 1'b0;
        do @(posedge mclk); while (config_valid !== 1'b1);
    endtask : restart
    task summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge mclk);
        check("factory at power-up", 32'h0A400000, applied);
        por_rst <= 1'b0;
        sys_rst <= 1'b0;
        do @(posedge mclk); while (config_valid !== 1'b1);
        prev = 32'h0A400000;
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 4; i++) begin
                bus(1'b1, 5'(4 * i), {24'h000000, rows[r][8 * i +: 8]}, rd);
            end
            for (int i = 0; i < 4; i++) begin
                bus(1'b0, 5'(4 * i), 32'h00000000, rd);
                check("latch byte", {24'h000000, rows[r][8 * i +: 8]}, rd);
            end
            bus(1'b0, 5'h14, 32'h00000000, rd);
            check("applied before reset", prev, rd);
            check("outputs before reset", prev, applied);
            restart();
            check("outputs", rows[r], applied);
            prev = rows[r];
            $display("row %0d done", r);
        end
        bus(1'b0, 5'h10, 32'h00000000, rd);
        check("status", 32'h00100001, rd);
        bus(1'b1, 5'h18, 32'h000000FF, rd);
        bus(1'b0, 5'h18, 32'h00000000, rd);
        check("unmapped", 32'h00000000, rd);
        avs_byteenable <= 4'hE;
        bus(1'b1, 5'h0C, 32'h00000011, rd);
        avs_byteenable <= 4'hF;
        bus(1'b1, 5'h14, 32'hFFFFFFFF, rd);
        bus(1'b0, 5'h0F, 32'h00000000, rd);
        check("masked write", 32'h0000000E, rd);
        // Request raised while the boot load runs must wait for it
        @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        bus(1'b0, 5'h10, 32'h00000000, rd);
        check("early request", 32'h00100001, rd);
        restart();
        check("after ignored writes", rows[3], applied);
        $display("awkward cases done");
        summarize();
    end
endmodule : bcl_boot_config_latches_tb
